/* adc_conversion_control.sv */
// Conversion control, result registers and Wishbone slave of the converter
//
// Summary of operation
// - Single mode: each go write starts one conversion
// - Free running: one go write, then continuous conversions
// - First conversion after enable 25 cycles, else 13
// - Go bit reads busy; writing zero does nothing
// - Auto trigger starts conversion on source rising edge
// - Done flag set at each conversion end, even when results are locked
// - Interrupt requested when flag, enable, global enable set
// - Flag cleared by vector taken or writing one
// - Prescaler code selects divide by 2 to 128
// - Low read locks results until high read
// - Right aligned: high holds bits 9:8, low 7:0
// - Left aligned: high holds 9:2, low 1:0 at top
// - Alignment change reformats results at once
// - Bipolar two's complement, unipolar ten bit unsigned
// - Unipolar differential non-positive input saturates to reference
// - Trigger source ignored without auto triggering
// - Switching to a set source triggers when enabled
// - Free running source code never triggers itself
// - Trigger source codes 1 to 7 map to seven event flags
// - Reserved bits 5 and 3 store written values
// - Buffer disable bit forces pin read to zero
// - Clearing converter enable aborts running conversion
// - Input select change applies after current conversion
`timescale 1ns/100ps
module adc_conversion_control (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic global_irq_enable_i,
   input wire logic irq_vector_taken_i,
   output logic irq_o,
   input wire logic [7:1] trigger_flags_i,
   input wire logic [10:0] analog_sample_i,
   output logic converting_o,
   output logic [5:0] input_select_o,
   input wire logic [7:0] pin_level_i,
   output logic [7:0] pin_read_o,
   output logic [7:0] pin_buffer_off_bits_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   conv_link_if link ();

   adc_ctrl_pkg::conv_state_type state_reg;
   adc_ctrl_pkg::conv_state_type state_next;

   logic converter_on_bit;
   logic auto_trigger_enable;
   logic conversion_done_flag;
   logic conversion_done_irq_enable;
   logic [2:0] clock_divider_select;
   logic [7:0] control_status_b_reg;
   logic [7:0] pin_buffer_disable_reg;
   logic [5:0] input_select_field;
   logic [9:0] conversion_result;
   logic result_lock_reg;
   logic init_needed_reg;
   logic [4:0] tick_count_reg;
   logic [4:0] length_reg;

   logic take;
   logic write_take;
   logic read_take;
   logic [5:0] index;
   logic csa_write;
   logic enable_after_write;
   logic go_request;
   logic start_request;
   logic finish;
   logic free_running;
   logic left_align_bit;
   logic bipolar_select;
   logic [7:0] read_value;
   logic [7:0] result_low_reg;
   logic [7:0] result_high_reg;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Differential when the select code names a channel pair
   function automatic logic is_differential(input logic [5:0] sel);
      return (sel >= 6'h08 && sel <= 6'h1f) || (sel >= 6'h23);
   endfunction : is_differential

   // Turns the signed front end sample into the stored result
   function automatic logic [9:0] format_sample(input logic [10:0] sample,
                                                input logic diff,
                                                input logic bipolar);
      logic [9:0] value;
      value = sample[9:0];
      if (diff && bipolar)
         value = sample[10:1];
      else if (diff && (sample[10] || sample == 11'h000))
         value = adc_ctrl_pkg::SATURATED_RESULT;
      else if (sample[10])
         value = 10'h000;
      return value;
   endfunction : format_sample

   // ----------------------------------------------------------------
   // Sub blocks
   // ----------------------------------------------------------------
   assign link.adc_enable = converter_on_bit;
   assign link.divider_select = clock_divider_select;
   assign link.trigger_flags = trigger_flags_i;
   assign link.source_select = control_status_b_reg[2:0];
   assign link.auto_enable = auto_trigger_enable;

   clock_prescaler prescaler_inst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .link(link.prescaler)
   );

   trigger_edge_detect trigger_inst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .link(link.trigger)
   );

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign index = wb_adr_i[7:2];
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign write_take = take && wb_we_i && wb_sel_i[0];
   assign read_take = take && !wb_we_i;
   assign csa_write = write_take &&
                      index == adc_ctrl_pkg::CONTROL_STATUS_A_IDX;
   assign enable_after_write = csa_write ?
                               wb_dat_i[adc_ctrl_pkg::CSA_ON_BIT] :
                               converter_on_bit;
   assign left_align_bit = control_status_b_reg[adc_ctrl_pkg::CSB_LEFT_ALIGN_BIT];
   assign bipolar_select = control_status_b_reg[adc_ctrl_pkg::CSB_BIPOLAR_BIT];

   // ----------------------------------------------------------------
   // Conversion sequencing
   // ----------------------------------------------------------------
   assign go_request = csa_write && wb_dat_i[adc_ctrl_pkg::CSA_GO_BIT] &&
                       enable_after_write;
   assign free_running = auto_trigger_enable &&
                         control_status_b_reg[2:0] ==
                         adc_ctrl_pkg::FREE_RUNNING_SOURCE;
   assign start_request = go_request || link.trigger_pulse;
   assign finish = state_reg == adc_ctrl_pkg::convert_state &&
                   enable_after_write && link.converter_tick &&
                   tick_count_reg == length_reg - 5'd1;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         adc_ctrl_pkg::idle_state:
            if (start_request && enable_after_write)
               state_next = adc_ctrl_pkg::convert_state;
         adc_ctrl_pkg::convert_state:
            if (!enable_after_write)
               state_next = adc_ctrl_pkg::idle_state;
            else if (finish && !free_running)
               state_next = adc_ctrl_pkg::idle_state;
         default:
            state_next = adc_ctrl_pkg::idle_state;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state_reg <= adc_ctrl_pkg::idle_state;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         converting_o <= 1'b0;
      else
         converting_o <= state_next == adc_ctrl_pkg::convert_state;
   end

   // Counts converter clock ticks within one conversion
   always_ff @(posedge clk_i)
   begin
      if (rst_i || state_reg == adc_ctrl_pkg::idle_state || finish)
         tick_count_reg <= 5'd0;
      else if (link.converter_tick)
         tick_count_reg <= tick_count_reg + 5'd1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         length_reg <= adc_ctrl_pkg::NORMAL_CONVERSION_CYCLES;
      else if (state_reg == adc_ctrl_pkg::idle_state)
         length_reg <= init_needed_reg ?
                       adc_ctrl_pkg::FIRST_CONVERSION_CYCLES :
                       adc_ctrl_pkg::NORMAL_CONVERSION_CYCLES;
      else if (finish)
         length_reg <= adc_ctrl_pkg::NORMAL_CONVERSION_CYCLES;
   end

   // Initialization pending from every switch-off until one conversion ends
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !converter_on_bit)
         init_needed_reg <= 1'b1;
      else if (finish)
         init_needed_reg <= 1'b0;
   end

   // Channel select is only passed to the front end between conversions
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         input_select_o <= adc_ctrl_pkg::INPUT_SELECT_RESET;
      else if (state_reg == adc_ctrl_pkg::idle_state || finish)
         input_select_o <= input_select_field;
   end

   // ----------------------------------------------------------------
   // Control/status A
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         converter_on_bit <= adc_ctrl_pkg::CONTROL_STATUS_A_RESET[7];
         auto_trigger_enable <= adc_ctrl_pkg::CONTROL_STATUS_A_RESET[5];
         conversion_done_irq_enable <= adc_ctrl_pkg::CONTROL_STATUS_A_RESET[3];
         clock_divider_select <= adc_ctrl_pkg::CONTROL_STATUS_A_RESET[2:0];
      end
      else if (csa_write)
      begin
         converter_on_bit <= wb_dat_i[adc_ctrl_pkg::CSA_ON_BIT];
         auto_trigger_enable <= wb_dat_i[adc_ctrl_pkg::CSA_AUTO_BIT];
         conversion_done_irq_enable <= wb_dat_i[adc_ctrl_pkg::CSA_IRQ_EN_BIT];
         clock_divider_select <= wb_dat_i[adc_ctrl_pkg::CSA_DIV_LSB +: 3];
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         conversion_done_flag <= adc_ctrl_pkg::CONTROL_STATUS_A_RESET[4];
      else if (finish)
         conversion_done_flag <= 1'b1;
      else if (irq_vector_taken_i ||
               (csa_write && wb_dat_i[adc_ctrl_pkg::CSA_DONE_BIT]))
         conversion_done_flag <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= conversion_done_flag && conversion_done_irq_enable &&
                  global_irq_enable_i;
   end

   // ----------------------------------------------------------------
   // Control/status B, input select and pin buffers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         control_status_b_reg <= adc_ctrl_pkg::CONTROL_STATUS_B_RESET;
      else if (write_take && index == adc_ctrl_pkg::CONTROL_STATUS_B_IDX)
         control_status_b_reg <= wb_dat_i[7:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         input_select_field <= adc_ctrl_pkg::INPUT_SELECT_RESET;
      else if (write_take && index == adc_ctrl_pkg::INPUT_SELECT_IDX)
         input_select_field <= wb_dat_i[5:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pin_buffer_disable_reg <= adc_ctrl_pkg::PIN_BUFFER_DISABLE_RESET;
      else if (write_take && index == adc_ctrl_pkg::PIN_BUFFER_DISABLE_IDX)
         pin_buffer_disable_reg <= wb_dat_i[7:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_read_o <= 8'h00;
         pin_buffer_off_bits_o <= adc_ctrl_pkg::PIN_BUFFER_DISABLE_RESET;
      end
      else
      begin
         pin_read_o <= pin_level_i & ~pin_buffer_disable_reg;
         pin_buffer_off_bits_o <= pin_buffer_disable_reg;
      end
   end

   // ----------------------------------------------------------------
   // Result storage and read lock
   // ----------------------------------------------------------------
   // A low read in progress also blocks an update in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         conversion_result <= adc_ctrl_pkg::RESULT_RESET;
      else if (finish && !result_lock_reg &&
               !(read_take && index == adc_ctrl_pkg::RESULT_LOW_IDX))
         conversion_result <= format_sample(analog_sample_i,
                                            is_differential(input_select_o),
                                            bipolar_select);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         result_lock_reg <= 1'b0;
      else if (read_take && index == adc_ctrl_pkg::RESULT_LOW_IDX)
         result_lock_reg <= 1'b1;
      else if (read_take && index == adc_ctrl_pkg::RESULT_HIGH_IDX)
         result_lock_reg <= 1'b0;
   end

   // Formatting is applied on every read, so alignment acts at once
   always_comb
   begin
      if (left_align_bit)
      begin
         result_high_reg = conversion_result[9:2];
         result_low_reg = {conversion_result[1:0], 6'h00};
      end
      else
      begin
         result_high_reg = {6'h00, conversion_result[9:8]};
         result_low_reg = conversion_result[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Read multiplexer and bus answer
   // ----------------------------------------------------------------
   always_comb
   begin
      case (index)
         adc_ctrl_pkg::PIN_BUFFER_DISABLE_IDX:
            read_value = pin_buffer_disable_reg;
         adc_ctrl_pkg::CONTROL_STATUS_B_IDX:
            read_value = control_status_b_reg;
         adc_ctrl_pkg::RESULT_LOW_IDX:
            read_value = result_low_reg;
         adc_ctrl_pkg::RESULT_HIGH_IDX:
            read_value = result_high_reg;
         adc_ctrl_pkg::CONTROL_STATUS_A_IDX:
            read_value = {converter_on_bit, converting_o,
                          auto_trigger_enable, conversion_done_flag,
                          conversion_done_irq_enable,
                          clock_divider_select};
         adc_ctrl_pkg::INPUT_SELECT_IDX:
            read_value = {2'h0, input_select_field};
         default:
            read_value = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= take;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h00000000;
      else if (read_take)
         wb_dat_o <= {24'h000000, read_value};
   end

endmodule : adc_conversion_control

/* adc_ctrl_pkg.sv */
// Package with register map, field positions and timing of the converter control
package adc_ctrl_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] PIN_BUFFER_DISABLE_IDX = 6'h01;
   localparam logic [5:0] CONTROL_STATUS_B_IDX = 6'h03;
   localparam logic [5:0] RESULT_LOW_IDX = 6'h04;
   localparam logic [5:0] RESULT_HIGH_IDX = 6'h05;
   localparam logic [5:0] CONTROL_STATUS_A_IDX = 6'h06;
   localparam logic [5:0] INPUT_SELECT_IDX = 6'h07;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] PIN_BUFFER_DISABLE_RESET = 8'h00;
   localparam logic [7:0] CONTROL_STATUS_B_RESET = 8'h00;
   localparam logic [7:0] CONTROL_STATUS_A_RESET = 8'h00;
   localparam logic [5:0] INPUT_SELECT_RESET = 6'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;

   // ----------------------------------------------------------------
   // Control/status A bit positions
   // ----------------------------------------------------------------
   localparam int CSA_ON_BIT = 7;
   localparam int CSA_GO_BIT = 6;
   localparam int CSA_AUTO_BIT = 5;
   localparam int CSA_DONE_BIT = 4;
   localparam int CSA_IRQ_EN_BIT = 3;
   localparam int CSA_DIV_LSB = 0;

   // ----------------------------------------------------------------
   // Control/status B bit positions
   // ----------------------------------------------------------------
   localparam int CSB_BIPOLAR_BIT = 7;
   localparam int CSB_LEFT_ALIGN_BIT = 4;
   localparam int CSB_SOURCE_LSB = 0;

   // ----------------------------------------------------------------
   // Conversion lengths in converter clock cycles, codes and limits
   // ----------------------------------------------------------------
   localparam logic [4:0] FIRST_CONVERSION_CYCLES = 5'd25;
   localparam logic [4:0] NORMAL_CONVERSION_CYCLES = 5'd13;
   localparam logic [2:0] FREE_RUNNING_SOURCE = 3'h0;
   localparam logic [9:0] SATURATED_RESULT = 10'h3ff;

   typedef enum logic {idle_state, convert_state} conv_state_type;

   // Terminal count of the prescaler: division factor minus one
   function automatic logic [6:0] divider_limit(input logic [2:0] sel);
      logic [7:0] factor;
      factor = (sel <= 3'h1) ? 8'h02 : (8'h01 << sel);
      return 7'(factor - 8'h01);
   endfunction : divider_limit

endpackage : adc_ctrl_pkg

/* adc_ctrl_sva.sv */
// Assertion checker for the converter control block
`timescale 1ns/100ps
module adc_ctrl_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic global_irq_enable_i,
   input wire logic irq_vector_taken_i,
   input wire logic irq_o,
   input wire logic converting_o,
   input wire logic [7:0] pin_level_i,
   input wire logic [7:0] pin_read_o,
   input wire logic [7:0] pin_buffer_off_bits_o
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire ctl_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h06;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (take |=> wb_ack_o)
      else $error("ack missing");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   AST_GO_START: assert property (ctl_wr && wb_dat_i[7] && wb_dat_i[6] &&
      !converting_o |=> converting_o) else $error("go ignored");
   AST_GO_MIN: assert property ($rose(converting_o) |-> converting_o[*8])
      else $error("conversion too short");
   AST_ABORT: assert property (ctl_wr && !wb_dat_i[7] |=> !converting_o)
      else $error("abort ignored");
   AST_IRQ_GLOBAL: assert property (irq_o |-> $past(global_irq_enable_i))
      else $error("irq without global enable");
   AST_IRQ_CLEAR: assert property (irq_vector_taken_i && !converting_o
      |=> ##1 !irq_o) else $error("irq kept after vector");
   AST_PIN_READ: assert property ($stable(pin_buffer_off_bits_o) |=>
      pin_read_o == ($past(pin_level_i) & ~pin_buffer_off_bits_o))
      else $error("pin read wrong");
   cover property (ctl_wr && wb_dat_i[6]);
   cover property ($fell(converting_o));
   cover property (irq_o);
endmodule : adc_ctrl_sva

bind adc_conversion_control adc_ctrl_sva chk_i (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .global_irq_enable_i(global_irq_enable_i),
   .irq_vector_taken_i(irq_vector_taken_i), .irq_o(irq_o),
   .converting_o(converting_o), .pin_level_i(pin_level_i),
   .pin_read_o(pin_read_o), .pin_buffer_off_bits_o(pin_buffer_off_bits_o));

/* clock_prescaler.sv */
// Converter clock enable derived from the system clock
`timescale 1ns/100ps
module clock_prescaler (
   input wire logic clk_i,
   input wire logic rst_i,
   conv_link_if.prescaler link
);
   logic [6:0] count_reg;
   logic [6:0] limit;

   assign limit = adc_ctrl_pkg::divider_limit(link.divider_select);

   // ----------------------------------------------------------------
   // Divider counter, held cleared while the converter is off
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !link.adc_enable || count_reg >= limit)
         count_reg <= 7'h00;
      else
         count_reg <= count_reg + 7'h01;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         link.converter_tick <= 1'b0;
      else
         link.converter_tick <= link.adc_enable && count_reg >= limit;
   end
endmodule : clock_prescaler

/* conv_link_if.sv */
// Interface joining the control core to its prescaler and trigger detector
`timescale 1ns/100ps
interface conv_link_if;
   logic adc_enable;
   logic [2:0] divider_select;
   logic converter_tick;
   logic [7:1] trigger_flags;
   logic [2:0] source_select;
   logic auto_enable;
   logic trigger_pulse;

   modport prescaler (input adc_enable, input divider_select,
                      output converter_tick);
   modport trigger (input adc_enable, input trigger_flags,
                    input source_select, input auto_enable,
                    output trigger_pulse);
   modport control (output adc_enable, output divider_select,
                    output trigger_flags, output source_select,
                    output auto_enable, input converter_tick,
                    input trigger_pulse);
endinterface : conv_link_if

/* tb_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module tb_top;
   logic clk_i, rst_i, cyc, we, glob, vec, ack, irq, busy;
   logic [7:0] adr, rd, pin_lvl, pin_rd, off_o;
   logic [5:0] sel_o;
   logic [31:0] wdat, rdat;
   logic [7:1] flags;
   logic [10:0] sample;
   int n_fail = 0;
   int n_tests = 0;
   adc_conversion_control DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .global_irq_enable_i(glob), .irq_vector_taken_i(vec), .irq_o(irq),
      .trigger_flags_i(flags), .analog_sample_i(sample),
      .converting_o(busy), .input_select_o(sel_o), .pin_level_i(pin_lvl),
      .pin_read_o(pin_rd), .pin_buffer_off_bits_o(off_o));
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h0, d};
      @(posedge clk_i);
      while (ack !== 1'b1)
         @(posedge clk_i);
      rd = rdat[7:0];
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic rc(input logic [5:0] i, input logic [7:0] e, input string nm);
      bus(1'b0, i, 8'h00);
      chk(nm, e, rd);
   endtask : rc
   // Waits for the end of a conversion; k ticks of dv clocks when k > 0
   task automatic wt(input int k, input int dv);
      int n;
      for (n = 0; busy === 1'b1 && n < 5000; n++)
         @(posedge clk_i);
      @(posedge clk_i);
      chk("idle", 8'h00, {7'h0, busy});
      if (k > 0)
         chk("length", 8'h01, {7'h0, n >= k * dv - dv - 1 && n <= k * dv});
   endtask : wt
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   initial
   begin
      #1200000;
      n_fail++;
      conclude();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      rst_i = 1'b1;
      {cyc, we, glob, vec, adr, wdat, flags, sample, pin_lvl} = '0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 1; i < 8; i++)
         rc(6'(i), 8'h00, "reset");
      bus(1'b1, 6'h01, 8'ha5);
      pin_lvl <= 8'hff;
      rc(6'h01, 8'ha5, "buf_off");
      chk("pin_read", 8'h5a, pin_rd);
      chk("buf_bits", 8'ha5, off_o);
      bus(1'b1, 6'h03, 8'h28);
      rc(6'h03, 8'h28, "reserved");
      $display("Test registers done");
      sample <= 11'h2b7;
      bus(1'b1, 6'h06, 8'hc0);
      wt(25, 2);
      rc(6'h06, 8'h90, "status");
      rc(6'h04, 8'hb7, "low_r");
      rc(6'h05, 8'h02, "high_r");
      bus(1'b1, 6'h03, 8'h38);
      rc(6'h04, 8'hc0, "low_l");
      sample <= 11'h0c1;
      bus(1'b1, 6'h06, 8'hc0);
      wt(13, 2);
      rc(6'h05, 8'had, "high_lock");
      bus(1'b1, 6'h06, 8'hc0);
      wt(13, 2);
      rc(6'h04, 8'h40, "low_new");
      rc(6'h05, 8'h30, "high_new");
      $display("Test results done");
      glob <= 1'b1;
      for (int c = 0; c < 8; c++)
      begin
         bus(1'b1, 6'h06, 8'hd8 | 8'(c));
         wt(13, c < 2 ? 2 : 1 << c);
         chk("irq_set", 8'h01, {7'h0, irq});
      end
      glob <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("irq_mask", 8'h00, {7'h0, irq});
      glob <= 1'b1;
      vec <= 1'b1;
      @(posedge clk_i);
      vec <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("irq_taken", 8'h00, {7'h0, irq});
      rc(6'h06, 8'h8f, "flag_clr");
      $display("Test prescaler done");
      bus(1'b1, 6'h03, 8'h02);
      bus(1'b1, 6'h06, 8'h81);
      flags <= 7'h02;
      repeat (4) @(posedge clk_i);
      chk("no_auto", 8'h00, {7'h0, busy});
      flags <= 7'h00;
      bus(1'b1, 6'h06, 8'ha1);
      flags <= 7'h02;
      repeat (4) @(posedge clk_i);
      chk("auto", 8'h01, {7'h0, busy});
      bus(1'b1, 6'h07, 8'h03);
      chk("sel_hold", 8'h00, {2'h0, sel_o});
      wt(0, 2);
      chk("sel_new", 8'h03, {2'h0, sel_o});
      flags <= 7'h10;
      bus(1'b1, 6'h03, 8'h05);
      repeat (4) @(posedge clk_i);
      chk("switch", 8'h01, {7'h0, busy});
      wt(0, 2);
      bus(1'b1, 6'h03, 8'h00);
      repeat (4) @(posedge clk_i);
      chk("free_sel", 8'h00, {7'h0, busy});
      bus(1'b1, 6'h06, 8'hf1);
      repeat (100) @(posedge clk_i);
      rc(6'h06, 8'hf1, "free_run");
      bus(1'b1, 6'h06, 8'h01);
      chk("abort", 8'h00, {7'h0, busy});
      $display("Test triggers done");
      bus(1'b1, 6'h07, 8'h08);
      sample <= 11'h7f0;
      for (int b = 0; b < 2; b++)
      begin
         bus(1'b1, 6'h03, b ? 8'h80 : 8'h00);
         bus(1'b1, 6'h06, 8'hc0);
         wt(b ? 13 : 25, 2);
         rc(6'h04, b ? 8'hf8 : 8'hff, "low_diff");
         rc(6'h05, 8'h03, "high_diff");
      end
      $display("Test formats done");
      conclude();
   end
endmodule : tb_top

/* trigger_edge_detect.sv */
// Rising edge detector on the selected auto trigger source
`timescale 1ns/100ps
module trigger_edge_detect (
   input wire logic clk_i,
   input wire logic rst_i,
   conv_link_if.trigger link
);
   logic selected;
   logic previous_reg;

   // Free running code selects a constant low, so it never makes an edge
   assign selected = (link.source_select == adc_ctrl_pkg::FREE_RUNNING_SOURCE)
                     ? 1'b0 : link.trigger_flags[link.source_select];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         previous_reg <= 1'b0;
      else
         previous_reg <= selected;
   end

   // ----------------------------------------------------------------
   // Edge also seen when software switches to a set source
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         link.trigger_pulse <= 1'b0;
      else
         link.trigger_pulse <= link.auto_enable && link.adc_enable &&
                               selected && !previous_reg;
   end
endmodule : trigger_edge_detect
